// ==== hdl/uart_line_status_modem_control.sv ====
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "uart_lsr_defs.svh"

// How it works
// RL1: Without FIFO mode the receive FIFO error flag always reads zero.
// RL2: In FIFO mode an errored byte entering the queue sets the FIFO error flag.
// RL3: Line status read clears FIFO error flag only when no errored bytes remain queued.
// RL4: Transmitter-all-empty reads one only when shift register and holding queue are empty.
// RL5: Single-buffer mode: holding empty sets when the byte moves to shift register; may interrupt.
// RL6: FIFO mode: holding empty means queue empty; any CPU transmit write clears it.
// RL7: Silent line flag sets when a full character time of spacing was received.
// RL8: Framing error flag sets when a received character has no valid stop bit.
// RL9: Parity error flag sets when a received character has wrong parity.
// RL10: In FIFO mode the three error flags describe the byte at the queue head.
// RL11: Reading line status clears silent, framing, parity and overrun flags.
// RL12: Overrun sets when a new character arrives at a full queue; single-buffer mode overwrites the unread one, FIFO mode drops the new one.
// RL13: Receive ready is one while any received byte waits, zero when none remain.
// RL14: Loopback forces serial output high and isolates the external serial input.
// RL15: Loopback drives all modem output pins to their inactive level.
// RL16: Loopback feeds control bits 0..3 into DSR, CTS, RI and carrier detect.
// RL17: Loopback otherwise transmits, receives, flags and interrupts as normal.
// RL18: Interrupt output is driven only while control bit 3 is set.
// RL19: Control bit 2 acts only as looped ring indicate.
// RL20: Request-to-send pin, active low, is the inverse of control bit 1 outside loopback.
// RL21: Data-terminal-ready pin, active low, is the inverse of control bit 0 outside loopback.
// RL22: DSR status reads the inverted pin, or control bit 0 in loopback.
// RL23: FIFO mode is in force exactly while the FIFO enable bit is one.
// RL24: Status reads return pre-clear values; only reported bits are cleared afterwards.
module uart_line_status_modem_control import uart_lsr_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [`ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic rx_push_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_parity_err_i,
	input wire logic rx_framing_err_i,
	input wire logic rx_silent_i,
	output logic rx_line_o,
	input wire logic tx_line_i,
	input wire logic tx_pop_i,
	input wire logic tx_shift_empty_i,
	output logic [7:0] tx_byte_o,
	output logic tx_avail_o,
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	output logic dtr_n_o,
	output logic rts_n_o,
	input wire logic dsr_n_i,
	input wire logic cts_n_i,
	input wire logic ring_indicate_n_i,
	input wire logic carrier_detect_n_i,
	output logic irq_o
);
	state_t s;
	state_t next_s;
	logic [7:0] line_status;
	logic [7:0] modem_status;
	logic thr_empty;

	function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [2:0] idx);
		hit = (a[`ADDR_W-1:5] == '0) && (a[1:0] == 2'h0) && (a[4:2] == idx);
	endfunction

	function automatic logic mapped(input logic [`ADDR_W-1:0] a);
		mapped = hit(a, `IDX_DATA) | hit(a, `IDX_IRQ_EN) | hit(a, `IDX_FIFO_CTRL) |
			hit(a, `IDX_MODEM_CONTROL) | hit(a, `IDX_LINE_STATUS) | hit(a, `IDX_MODEM_STATUS);
	endfunction

	// Queue depth of one gives the single-buffer behaviour
	wire logic [4:0] cap = s.fifo_en ? `FIFO_DEPTH : `SINGLE_DEPTH; // see RL23
	wire logic loop = s.mc[`MC_LOOP];

	assign thr_empty = (s.tx_cnt == 5'h00); // see RL5 see RL6
	always_comb begin
		line_status = 8'h00;
		line_status[`LS_RX_READY] = (s.rx_cnt != 5'h00); // see RL13
		line_status[`LS_OVERRUN] = s.ov;
		line_status[`LS_PARITY] = s.pe;
		line_status[`LS_FRAMING] = s.fe;
		line_status[`LS_SILENT] = s.sl;
		line_status[`LS_THR_EMPTY] = thr_empty;
		line_status[`LS_ALL_EMPTY] = thr_empty & tx_shift_empty_i; // see RL4
		line_status[`LS_FIFO_ERR] = s.fifo_en & s.rfe; // see RL1
	end

	// Upper nibble: carrier detect, ring, DSR, CTS; looped from control bits
	always_comb begin
		modem_status = 8'h00;
		modem_status[7] = loop ? s.mc[`MC_IRQ_EN] : ~carrier_detect_n_i; // see RL16
		modem_status[6] = loop ? s.mc[`MC_LOOP_RI] : ~ring_indicate_n_i; // see RL19
		modem_status[5] = loop ? s.mc[`MC_DTR] : ~dsr_n_i; // see RL22
		modem_status[4] = loop ? s.mc[`MC_RTS] : ~cts_n_i;
	end

	always_comb begin
		logic acc;
		logic rd_op;
		logic wr_op;
		logic clr;
		logic rx_pop;
		logic tx_pop;
		logic [4:0] rx_eff;
		logic [4:0] tx_eff;
		logic head_new;
		logic push_err;
		logic ovw;
		rx_entry_t e;
		rx_entry_t h;
		acc = 1'b0;
		rd_op = 1'b0;
		wr_op = 1'b0;
		clr = 1'b0;
		rx_pop = 1'b0;
		tx_pop = 1'b0;
		rx_eff = 5'h00;
		tx_eff = 5'h00;
		head_new = 1'b0;
		push_err = 1'b0;
		ovw = 1'b0;
		e = {rx_silent_i, rx_framing_err_i, rx_parity_err_i, rx_byte_i};
		h = '0;
		next_s = s;

		// Bus: the access phase waits one cycle so read data comes from a flop
		acc = psel_i & penable_i;
		next_s.ack = acc & ~s.ack;
		rd_op = acc & s.ack & ~pwrite_i;
		wr_op = acc & s.ack & pwrite_i & mapped(paddr_i);
		if (acc & ~s.ack) begin
			next_s.rdata = 8'h00;
			if (hit(paddr_i, `IDX_DATA))
				next_s.rdata = (s.rx_cnt != 5'h00) ? s.rxq[s.rx_rd][7:0] : 8'h00;
			if (hit(paddr_i, `IDX_IRQ_EN))
				next_s.rdata = {4'h0, s.irq_en};
			if (hit(paddr_i, `IDX_FIFO_CTRL))
				next_s.rdata = {s.fifo_en, s.fifo_en, 6'h00};
			if (hit(paddr_i, `IDX_MODEM_CONTROL))
				next_s.rdata = {3'h0, s.mc};
			if (hit(paddr_i, `IDX_LINE_STATUS))
				next_s.rdata = line_status; // see RL24
			if (hit(paddr_i, `IDX_MODEM_STATUS))
				next_s.rdata = modem_status;
		end
		clr = rd_op & hit(paddr_i, `IDX_LINE_STATUS);

		// Receive queue
		rx_pop = rd_op & hit(paddr_i, `IDX_DATA) & (s.rx_cnt != 5'h00);
		if (rx_pop) begin
			next_s.rx_rd = s.rx_rd + 4'h1;
			next_s.rx_cnt = s.rx_cnt - 5'h01;
			if (|s.rxq[s.rx_rd][10:8])
				next_s.err_cnt = next_s.err_cnt - 5'h01;
			head_new = 1'b1;
		end
		rx_eff = next_s.rx_cnt;
		if (rx_push_i) begin
			push_err = |e[10:8];
			if (rx_eff < cap) begin
				next_s.rxq[s.rx_wr] = e;
				next_s.rx_wr = s.rx_wr + 4'h1;
				next_s.rx_cnt = rx_eff + 5'h01;
				if (push_err)
					next_s.err_cnt = next_s.err_cnt + 5'h01;
				if (rx_eff == 5'h00)
					head_new = 1'b1;
			end else if (!s.fifo_en) begin
				// Single buffer: the unread byte is replaced
				ovw = 1'b1;
				if (|s.rxq[next_s.rx_rd][10:8])
					next_s.err_cnt = next_s.err_cnt - 5'h01;
				if (push_err)
					next_s.err_cnt = next_s.err_cnt + 5'h01;
				next_s.rxq[next_s.rx_rd] = e;
				head_new = 1'b1;
			end else begin
				// Full queue: the incoming byte is lost, the queued ones kept
				push_err = 1'b0;
			end
		end

		// Clear only what the read reported, then apply new events
		next_s.pe = s.pe & ~(clr & s.rdata[`LS_PARITY]); // see RL11
		next_s.fe = s.fe & ~(clr & s.rdata[`LS_FRAMING]);
		next_s.sl = s.sl & ~(clr & s.rdata[`LS_SILENT]);
		next_s.ov = (s.ov & ~(clr & s.rdata[`LS_OVERRUN])) |
			(rx_push_i & (rx_eff >= cap)); // see RL12
		h = next_s.rxq[next_s.rx_rd];
		if (head_new && next_s.rx_cnt != 5'h00) begin
			next_s.pe = next_s.pe | h[`E_PARITY]; // see RL9 see RL10
			next_s.fe = next_s.fe | h[`E_FRAMING]; // see RL8
			next_s.sl = next_s.sl | h[`E_SILENT]; // see RL7
		end
		next_s.rfe = s.fifo_en & ((s.rfe & ~(clr & s.rdata[`LS_FIFO_ERR] &
			(next_s.err_cnt == 5'h00))) | (push_err & ~ovw)); // see RL2 see RL3

		// Transmit queue
		tx_pop = tx_pop_i & (s.tx_cnt != 5'h00);
		if (tx_pop) begin
			next_s.tx_rd = s.tx_rd + 4'h1;
			next_s.tx_cnt = s.tx_cnt - 5'h01;
		end
		tx_eff = next_s.tx_cnt;
		if (wr_op && hit(paddr_i, `IDX_DATA)) begin
			if (tx_eff < cap) begin
				next_s.txq[s.tx_wr] = pwdata_i[7:0];
				next_s.tx_wr = s.tx_wr + 4'h1;
				next_s.tx_cnt = tx_eff + 5'h01; // see RL6
			end else if (!s.fifo_en) begin
				next_s.txq[next_s.tx_rd] = pwdata_i[7:0];
			end
		end

		// Control registers
		if (wr_op && hit(paddr_i, `IDX_IRQ_EN))
			next_s.irq_en = pwdata_i[3:0];
		if (wr_op && hit(paddr_i, `IDX_MODEM_CONTROL))
			next_s.mc = pwdata_i[4:0];
		if (wr_op && hit(paddr_i, `IDX_FIFO_CTRL)) begin
			next_s.fifo_en = pwdata_i[`FC_ENABLE]; // see RL23
			// Switching mode flushes both queues so depth never exceeds capacity
			if (pwdata_i[`FC_RX_RESET] || pwdata_i[`FC_ENABLE] != s.fifo_en) begin
				next_s.rx_wr = 4'h0;
				next_s.rx_rd = 4'h0;
				next_s.rx_cnt = 5'h00;
				next_s.err_cnt = 5'h00;
				next_s.rfe = 1'b0;
			end
			if (pwdata_i[`FC_TX_RESET] || pwdata_i[`FC_ENABLE] != s.fifo_en) begin
				next_s.tx_wr = 4'h0;
				next_s.tx_rd = 4'h0;
				next_s.tx_cnt = 5'h00;
			end
		end

		// Pins: loopback reroutes, everything else keeps running
		next_s.serial_out_pin = loop | tx_line_i; // see RL14 see RL17
		next_s.rx_line = loop ? tx_line_i : serial_in_pin_i;
		next_s.dtr_n = loop | ~s.mc[`MC_DTR]; // see RL15 see RL21
		next_s.rts_n = loop | ~s.mc[`MC_RTS]; // see RL20
		next_s.irq = s.mc[`MC_IRQ_EN] & ( // see RL18
			(s.irq_en[0] & line_status[`LS_RX_READY]) |
			(s.irq_en[1] & thr_empty) | // see RL5
			(s.irq_en[2] & (s.ov | s.pe | s.fe | s.sl)));
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			s <= '0;
			s.serial_out_pin <= 1'b1;
			s.rx_line <= 1'b1;
			s.dtr_n <= 1'b1;
			s.rts_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign pready_o = s.ack;
	assign pslverr_o = s.ack & ~mapped(paddr_i);
	assign prdata_o = {24'h000000, s.rdata};
	assign tx_byte_o = s.txq[s.tx_rd];
	assign tx_avail_o = (s.tx_cnt != 5'h00);
	assign serial_out_pin_o = s.serial_out_pin;
	assign rx_line_o = s.rx_line;
	assign dtr_n_o = s.dtr_n;
	assign rts_n_o = s.rts_n;
	assign irq_o = s.irq;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence ls_read_done;
		psel_i && penable_i && !pwrite_i && s.ack && hit(paddr_i, `IDX_LINE_STATUS);
	endsequence
	sequence apb_access;
		psel_i && penable_i && !s.ack ##1 psel_i && penable_i && s.ack;
	endsequence
	sequence data_read_done;
		psel_i && penable_i && !pwrite_i && s.ack && hit(paddr_i, `IDX_DATA);
	endsequence
	sequence ctrl_write_done;
		psel_i && penable_i && pwrite_i && s.ack && hit(paddr_i, `IDX_FIFO_CTRL);
	endsequence

	a_fifo_err_zero: // see RL1
	assert property (!s.fifo_en |=> !line_status[`LS_FIFO_ERR])
		else $error("FIFO error flag set outside FIFO mode");
	a_all_empty_level: // see RL4
	assert property (line_status[`LS_ALL_EMPTY] |-> (s.tx_cnt == 5'h00) && tx_shift_empty_i)
		else $error("All-empty flag with data pending");
	a_thr_write_clears: // see RL6
	assert property (psel_i && penable_i && pwrite_i && s.ack && hit(paddr_i, `IDX_DATA) && !tx_pop_i
		|=> !thr_empty)
		else $error("Holding empty still set after a transmit write");
	a_read_clears_err: // see RL11
	assert property (ls_read_done ##0 (s.rdata[`LS_PARITY] && !rx_push_i) |=> !s.pe)
		else $error("Parity flag not cleared by status read");
	a_overrun_clears: // see RL11
	assert property (ls_read_done ##0 (s.rdata[`LS_OVERRUN] && !rx_push_i) |=> !s.ov)
		else $error("Overrun flag not cleared by status read");
	a_overrun_single: // see RL12
	assert property (!s.fifo_en && rx_push_i && s.rx_cnt == 5'h01 && !(psel_i && penable_i)
		|=> s.ov && line_status[`LS_RX_READY])
		else $error("Overwrite in single-buffer mode not flagged");
	a_ready_on_push: // see RL13
	assert property (rx_push_i && s.rx_cnt == 5'h00 |=> line_status[`LS_RX_READY] ##0 s.rx_cnt == 5'h01)
		else $error("Received byte not shown as ready");
	a_loop_serial_out_pin_high: // see RL14
	assert property (loop |=> serial_out_pin_o)
		else $error("Serial output not forced high in loopback");
	a_loop_pins_idle: // see RL15
	assert property (loop |=> dtr_n_o && rts_n_o)
		else $error("Modem outputs active in loopback");
	a_dtr_inverse: // see RL21
	assert property (!loop |=> dtr_n_o == !$past(s.mc[`MC_DTR]))
		else $error("DTR pin does not follow control bit");
	a_irq_gated: // see RL18
	assert property (!s.mc[`MC_IRQ_EN] |=> !irq_o)
		else $error("Interrupt driven while gate bit clear");
	a_read_timing: // see RL24
	assert property (apb_access |-> prdata_o[31:8] == 24'h000000 ##1 !pready_o)
		else $error("Access answer does not stand exactly one cycle");
	a_preclear_read: // see RL24
	assert property (psel_i && penable_i && !s.ack && !pwrite_i && hit(paddr_i, `IDX_LINE_STATUS)
		|=> prdata_o[7:0] == $past(line_status))
		else $error("Status read does not return the pre-clear flags");

	// Errors ride with the byte; a flag already set may stay set
	a_flags_on_push: // see RL9
	assert property (rx_push_i && s.rx_cnt == 5'h00 |=> (s.pe || !$past(rx_parity_err_i)) &&
		(s.fe || !$past(rx_framing_err_i)) && (s.sl || !$past(rx_silent_i)))
		else $error("Error flags of a fresh head byte not shown");
	a_fifo_err_set: // see RL2
	assert property (s.fifo_en && rx_push_i && (rx_parity_err_i || rx_framing_err_i || rx_silent_i) &&
		s.rx_cnt < `FIFO_DEPTH && !(psel_i && penable_i) |=> line_status[`LS_FIFO_ERR])
		else $error("Errored byte in FIFO mode did not set the FIFO error flag");
	a_fifo_err_keep: // see RL3
	assert property (ls_read_done ##0 (s.rfe && s.err_cnt != 5'h00) |=> s.rfe)
		else $error("FIFO error flag cleared while errored bytes remain");
	a_fifo_err_clear: // see RL3
	assert property (ls_read_done ##0 (s.rdata[`LS_FIFO_ERR] && s.err_cnt == 5'h00 && !rx_push_i) |=> !s.rfe)
		else $error("FIFO error flag not cleared with no errored bytes left");
	a_overrun_fifo: // see RL12
	assert property (s.fifo_en && rx_push_i && s.rx_cnt == `FIFO_DEPTH && !(psel_i && penable_i) |=> s.ov)
		else $error("Push into a full FIFO not flagged as overrun");
	a_ready_on_pop: // see RL13
	assert property (data_read_done ##0 (s.rx_cnt == 5'h01 && !rx_push_i) |=> !line_status[`LS_RX_READY])
		else $error("Receive ready still set with no byte left");

	a_thr_empty_pop: // see RL5
	assert property (tx_pop_i && s.tx_cnt == 5'h01 && !(psel_i && penable_i && pwrite_i)
		|=> line_status[`LS_THR_EMPTY])
		else $error("Holding empty not set after the last byte moved on");
	a_thr_irq: // see RL5
	assert property (s.mc[`MC_IRQ_EN] && s.irq_en[1] && thr_empty |=> irq_o)
		else $error("Holding empty did not raise the enabled interrupt");
	a_fifo_mode_bit: // see RL23
	assert property (ctrl_write_done |=> s.fifo_en == $past(pwdata_i[`FC_ENABLE]))
		else $error("FIFO mode does not follow the enable bit");
	a_mode_flush: // see RL23
	assert property (ctrl_write_done ##0 (pwdata_i[`FC_ENABLE] != s.fifo_en)
		|=> !line_status[`LS_RX_READY] && !tx_avail_o)
		else $error("Queues not empty after a mode change");

	a_rts_inverse: // see RL20
	assert property (!loop |=> rts_n_o == !$past(s.mc[`MC_RTS]))
		else $error("RTS pin does not follow control bit");
	a_loop_rx_path: // see RL14
	assert property (loop |=> rx_line_o == $past(tx_line_i))
		else $error("Receive line not fed from transmit line in loopback");
	a_pin_rx_path: // see RL14
	assert property (!loop |=> rx_line_o == $past(serial_in_pin_i))
		else $error("Receive line not fed from the serial input pin");
endmodule

// ==== hdl/uart_lsr_defs.svh ====
`ifndef UART_LSR_DEFS_SVH
`define UART_LSR_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_DATA 3'h0
`define IDX_IRQ_EN 3'h1
`define IDX_FIFO_CTRL 3'h2
`define IDX_MODEM_CONTROL 3'h4
`define IDX_LINE_STATUS 3'h5
`define IDX_MODEM_STATUS 3'h6
`define ADDR_W 12

// Line status bit positions
`define LS_RX_READY 0
`define LS_OVERRUN 1
`define LS_PARITY 2
`define LS_FRAMING 3
`define LS_SILENT 4
`define LS_THR_EMPTY 5
`define LS_ALL_EMPTY 6
`define LS_FIFO_ERR 7

// Modem control bit positions
`define MC_DTR 0
`define MC_RTS 1
`define MC_LOOP_RI 2
`define MC_IRQ_EN 3
`define MC_LOOP 4

// FIFO control bit positions
`define FC_ENABLE 0
`define FC_RX_RESET 1
`define FC_TX_RESET 2

// Queue entry layout: data in 7:0, then error bits
`define E_PARITY 8
`define E_FRAMING 9
`define E_SILENT 10

`define FIFO_DEPTH 5'h10
`define SINGLE_DEPTH 5'h01

`endif

// ==== hdl/uart_lsr_pkg.sv ====
package uart_lsr_pkg;
	typedef logic [10:0] rx_entry_t;

	typedef struct packed {
		rx_entry_t [15:0] rxq;
		logic [3:0] rx_wr;
		logic [3:0] rx_rd;
		logic [4:0] rx_cnt;
		logic [4:0] err_cnt;
		logic [15:0][7:0] txq;
		logic [3:0] tx_wr;
		logic [3:0] tx_rd;
		logic [4:0] tx_cnt;
		logic pe;
		logic fe;
		logic sl;
		logic ov;
		logic rfe;
		logic fifo_en;
		logic [3:0] irq_en;
		logic [4:0] mc;
		logic ack;
		logic [7:0] rdata;
		logic serial_out_pin;
		logic dtr_n;
		logic rts_n;
		logic rx_line;
		logic irq;
	} state_t;
endpackage

// ==== sim/line_partner.sv ====
`timescale 1ns/1ns
module line_partner (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hold_i,
	input wire logic [3:0] mdm_n_i,
	input wire logic tx_avail_i,
	input wire logic [7:0] tx_byte_i,
	output logic tx_pop_o,
	output logic tx_shift_empty_o,
	output logic tx_line_o,
	output logic dsr_n_o,
	output logic cts_n_o,
	output logic ring_indicate_n_o,
	output logic carrier_detect_n_o
);
	logic [9:0] frame = 10'h3FF;
	logic [4:0] cnt = 5'h00;
	always @(posedge clk_i) begin
		{carrier_detect_n_o, ring_indicate_n_o, dsr_n_o, cts_n_o} <= mdm_n_i;
		tx_pop_o <= 1'b0;
		if (rst_i) begin
			cnt <= 5'h00;
			tx_line_o <= 1'b1;
		end else if (cnt != 5'h00) begin
			cnt <= cnt - 5'h01;
			tx_line_o <= frame[0];
			frame <= {1'b1, frame[9:1]};
		end else if (tx_avail_i && !hold_i && !tx_pop_o) begin
			// Skip the cycle after a pop: the queue flag lags it by one
			tx_pop_o <= 1'b1;
			frame <= {1'b1, tx_byte_i, 1'b0};
			cnt <= 5'h14;
		end else begin
			tx_line_o <= 1'b1;
		end
	end
	assign tx_shift_empty_o = (cnt == 5'h00) && !tx_pop_o;
endmodule

// ==== sim/uart_line_status_modem_control_tb.sv ====
`timescale 1ns/1ns
`include "uart_lsr_defs.svh"
module uart_line_status_modem_control_tb;
	logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h00000000;
	logic rx_push_i = 1'b0, rx_parity_err_i = 1'b0, rx_framing_err_i = 1'b0, rx_silent_i = 1'b0;
	logic [7:0] rx_byte_i = 8'h00;
	logic serial_in_pin_i = 1'b1, hold = 1'b1;
	logic [3:0] mdm_n = 4'hF;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, rx_line_o, tx_line_i, tx_pop_i, tx_shift_empty_i, tx_avail_o, irq_o;
	logic serial_out_pin_o, dtr_n_o, rts_n_o, dsr_n_i, cts_n_i, ring_indicate_n_i, carrier_detect_n_i;
	logic [7:0] tx_byte_o, rd, x;
	logic se;
	logic [31:0] seed = 32'h0000A38E;
	int fail_count = 0, checks_done = 0, ov, pe, fe, sl, rfe, fifo, txc, n;
	int q[$];
	uart_line_status_modem_control u_uart_line_status_modem_control (
		.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.rx_push_i(rx_push_i), .rx_byte_i(rx_byte_i), .rx_parity_err_i(rx_parity_err_i),
		.rx_framing_err_i(rx_framing_err_i), .rx_silent_i(rx_silent_i), .rx_line_o(rx_line_o),
		.tx_line_i(tx_line_i), .tx_pop_i(tx_pop_i), .tx_shift_empty_i(tx_shift_empty_i), .tx_byte_o(tx_byte_o),
		.tx_avail_o(tx_avail_o), .serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o),
		.dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o), .dsr_n_i(dsr_n_i), .cts_n_i(cts_n_i),
		.ring_indicate_n_i(ring_indicate_n_i), .carrier_detect_n_i(carrier_detect_n_i), .irq_o(irq_o));
	line_partner u_line_partner (.clk_i(sys_clk_i), .rst_i(sys_rst_i), .hold_i(hold), .mdm_n_i(mdm_n),
		.tx_avail_i(tx_avail_o), .tx_byte_i(tx_byte_o), .tx_pop_o(tx_pop_i), .tx_shift_empty_o(tx_shift_empty_i),
		.tx_line_o(tx_line_i), .dsr_n_o(dsr_n_i), .cts_n_o(cts_n_i), .ring_indicate_n_o(ring_indicate_n_i),
		.carrier_detect_n_o(carrier_detect_n_i));
	always #25 sys_clk_i = ~sys_clk_i;
	function automatic logic [7:0] r8();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [7:0] m_ls();
		return {fifo ? rfe[0] : 1'b0, txc == 0 && tx_shift_empty_i, txc == 0, sl[0], fe[0], pe[0], ov[0], q.size() != 0};
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic oops(input string s);
		$display("mismatch at %0t: %s", $time, s);
		fail_count++;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) oops($sformatf("got %h expected %h", got, exp));
	endtask
	task automatic check_pin(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) oops($sformatf("pin %b expected %b", got, exp));
	endtask
	task automatic wait_for(ref logic s, input logic v);
		for (n = 0; n < 60 && s !== v; n++) @(posedge sys_clk_i);
		if (s !== v) begin
			oops("wait timed out");
			summarize();
		end
	endtask
	task automatic apb(input logic wr, input logic [2:0] idx, input logic [7:0] wd);
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= {7'h00, idx, 2'b00};
		pwdata_i <= {24'h000000, wd};
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		wait_for(pready_o, 1'b1);
		rd = prdata_o[7:0];
		se = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] idx, input logic [7:0] exp, input logic [7:0] m);
		apb(1'b0, idx, 8'h00);
		check(rd & m, exp);
	endtask
	// A new head byte adds its errors; only a status read takes flags away
	task automatic load(input int v);
		pe |= v[8];
		fe |= v[9];
		sl |= v[10];
	endtask
	task automatic rd_ls();
		rd_reg(`IDX_LINE_STATUS, m_ls(), 8'hFF);
		ov = 0;
		pe = 0;
		fe = 0;
		sl = 0;
		n = 0;
		foreach (q[i]) n |= q[i] >> 8;
		if (n == 0) rfe = 0;
	endtask
	task automatic rd_data();
		rd_reg(`IDX_DATA, q[0][7:0], 8'hFF);
		void'(q.pop_front());
		if (fifo && q.size() != 0) load(q[0]);
	endtask
	task automatic push(input logic [2:0] e);
		x = r8();
		@(posedge sys_clk_i);
		rx_push_i <= 1'b1;
		rx_byte_i <= x;
		{rx_silent_i, rx_framing_err_i, rx_parity_err_i} <= e;
		@(posedge sys_clk_i);
		rx_push_i <= 1'b0;
		if (fifo && e != 0) rfe = 1;
		if (q.size() == 0) load({e, x});
		if (q.size() < (fifo ? 16 : 1)) begin
			q.push_back({e, x});
		end else begin
			// Single buffer overwrites its byte; a full queue drops the new one
			ov = 1;
			if (!fifo) begin
				q[0] = {e, x};
				load({e, x});
			end
		end
	endtask
	initial begin
		repeat (16) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		rd_ls();
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, `IDX_MODEM_CONTROL, i[7:0]);
			repeat (2) @(posedge sys_clk_i);
			check_pin(dtr_n_o, !i[0]);
			check_pin(rts_n_o, !i[1]);
		end
		mdm_n <= 4'h9;
		serial_in_pin_i <= 1'b0;
		rd_reg(`IDX_MODEM_STATUS, 8'h60, 8'hF0);
		check_pin(rx_line_o, 1'b0);
		apb(1'b1, `IDX_MODEM_CONTROL, 8'h1D);
		repeat (2) @(posedge sys_clk_i);
		check_pin(rx_line_o, 1'b1);
		check_pin(serial_out_pin_o, 1'b1);
		check_pin(dtr_n_o, 1'b1);
		check_pin(rts_n_o, 1'b1);
		rd_reg(`IDX_MODEM_STATUS, 8'hE0, 8'hF0);
		apb(1'b1, `IDX_MODEM_CONTROL, 8'h00);
		serial_in_pin_i <= 1'b1;
		apb(1'b0, 3'h7, 8'h00);
		check_pin(se, 1'b1);
		$display("test modem done");
		push(3'b101);
		rd_ls();
		rd_ls();
		push(3'b000);
		rd_ls();
		rd_data();
		rd_ls();
		$display("test single done");
		apb(1'b1, `IDX_IRQ_EN, 8'h02);
		apb(1'b1, `IDX_MODEM_CONTROL, 8'h08);
		repeat (2) @(posedge sys_clk_i);
		check_pin(irq_o, 1'b1);
		x = r8();
		apb(1'b1, `IDX_DATA, x);
		txc = 1;
		repeat (2) @(posedge sys_clk_i);
		check(tx_byte_o, x);
		rd_ls();
		check_pin(irq_o, 1'b0);
		hold <= 1'b0;
		wait_for(tx_avail_o, 1'b0);
		txc = 0;
		rd_ls();
		check_pin(irq_o, 1'b1);
		wait_for(tx_shift_empty_i, 1'b1);
		rd_ls();
		apb(1'b1, `IDX_MODEM_CONTROL, 8'h00);
		repeat (2) @(posedge sys_clk_i);
		check_pin(irq_o, 1'b0);
		$display("test transmit done");
		apb(1'b1, `IDX_FIFO_CTRL, 8'h01);
		fifo = 1;
		rd_reg(`IDX_FIFO_CTRL, 8'hC0, 8'hC0);
		push(3'b000);
		push(3'b010);
		push(3'b000);
		rd_ls();
		rd_data();
		rd_ls();
		rd_data();
		rd_ls();
		rd_ls();
		rd_data();
		rd_ls();
		$display("test fifo done");
		summarize();
	end
endmodule
